// File: rtl/nand_bank_pkg.sv
// Constants, field layout and types shared by the NAND bank option timing block
package nand_bank_pkg;

  // Register map (byte addresses)
  localparam logic [15:0] OPT_BASE_ADDR = 16'h5004;
  localparam logic [15:0] OPT_DEC_MASK  = 16'hffc7;
  localparam logic [15:0] STATUS_ADDR   = 16'h5040;

  // Option word field positions (bit 0 of the word is the least significant)
  localparam int AM_LSB    = 15;
  localparam int AM_W      = 17;
  localparam int BUFFER_CTL_DISABLE_BIT = 12;
  localparam int PGS_BIT   = 10;
  localparam int SELECT_LEAD_TIME_BIT  = 9;
  localparam int CST_BIT   = 8;
  localparam int CHT_BIT   = 7;
  localparam int SCY_LSB   = 4;
  localparam int SCY_W     = 3;
  localparam int RST_BIT   = 3;
  localparam int RELAXED_TIMING_BIT  = 2;
  localparam int READ_HOLD_EXTEND_BIT  = 1;

  localparam logic [31:0] OPT_WRITABLE = 32'hffff_97fe;
  localparam logic [31:0] OPT_RESET    = 32'h0000_0000;

  // Status word field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CS_BIT   = 1;
  localparam int STAT_BANK_LSB = 4;
  localparam int STAT_RB_BIT   = 8;
  localparam int STAT_WR_BIT   = 9;
  localparam int STAT_CA_BIT   = 10;

  // Timing: core cycles per local bus clock, so one core cycle is a quarter bus clock
  localparam int QTR_PER_LBC   = 4;
  localparam int STROBE_LBC    = 1;
  localparam int LEAD_LBC    [4] = '{1, 4, 2, 8};
  localparam int SETUP_QTR   [4] = '{0, 1, 2, 4};
  localparam int HOLD_QTR    [4] = '{2, 4, 6, 8};
  localparam int RDSETUP_QTR [4] = '{3, 4, 2, 4};
  localparam int IDLE_LBC    [4] = '{1, 2, 4, 8};
  localparam int SCY_BASE      = 2;
  localparam int WAIT_RLX_MULT = 2;
  localparam int GAP_MULT_NORM = 4;
  localparam int GAP_MULT_RLX  = 8;
  localparam int RB_MULT_NORM  = 8;
  localparam int RB_MULT_RLX   = 16;

  // Page geometry
  localparam logic [11:0] SMALL_MAIN  = 12'd512;
  localparam logic [6:0]  SMALL_SPARE = 7'd16;
  localparam logic [12:0] SMALL_BUF   = 13'd1024;
  localparam logic [17:0] SMALL_BLOCK = 18'd16384;
  localparam logic [11:0] LARGE_MAIN  = 12'd2048;
  localparam logic [6:0]  LARGE_SPARE = 7'd64;
  localparam logic [12:0] LARGE_BUF   = 13'd4096;
  localparam logic [17:0] LARGE_BLOCK = 18'd131072;

  typedef enum logic [2:0] {OP_CMD, OP_ADDR, OP_WDATA, OP_RDATA, OP_WAIT_RB} nand_op_e;

endpackage

// File: rtl/bank_option_reg.sv
// One bank option register with masked reserved bits
`timescale 1ns/100ps
module bank_option_reg
  import nand_bank_pkg::*;
#(
  parameter logic [31:0] RESET_VAL = OPT_RESET
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  output logic      [31:0] value
);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      value <= RESET_VAL & OPT_WRITABLE;
    else if (wr_en)
      value <= wdata & OPT_WRITABLE;
  end

endmodule

// File: rtl/delay_timer.sv
// Loadable down counter that flags when it reaches zero
`timescale 1ns/100ps
module delay_timer #(
  parameter int W = 16
)
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] count;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      count <= '0;
    else if (load)
      count <= load_val;
    else if (count != '0)
      count <= count - W'(1);
  end

  assign expired = (count == '0);

endmodule

// File: rtl/nand_bank_option_timing.sv
// NAND bank option registers and the access timing sequencer they steer
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
module nand_bank_option_timing
  import nand_bank_pkg::*;
#(
  parameter int          NUM_BANKS   = 8,
  parameter logic [31:0] BANK0_RESET = OPT_RESET,
  parameter int          TW          = 16
)
(
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [15:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [NUM_BANKS*AM_W-1:0] bank_base_flat,
  input  wire logic [NUM_BANKS-1:0]      bank_is_nand,
  input  wire logic                      req_valid,
  input  wire nand_op_e                  req_op,
  input  wire logic [31:0]               req_addr,
  input  wire logic [7:0]                req_wdata,
  input  wire logic                      req_end,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output logic                           rsp_miss,
  output logic      [7:0]                rsp_rdata,
  output logic      [NUM_BANKS-1:0]      bank_select_n,
  output logic                           flash_cle,
  output logic                           flash_ale,
  output logic                           flash_write_strobe_n,
  output logic                           flash_read_strobe_n,
  output logic      [7:0]                flash_data_out,
  output logic                           flash_data_oe,
  input  wire logic [7:0]                flash_data_in,
  input  wire logic                      flash_ready_busy_in,
  output logic                           buffer_ctl_out,
  output logic      [11:0]               page_main_bytes,
  output logic      [6:0]                page_spare_bytes,
  output logic      [12:0]               buffer_bytes,
  output logic      [17:0]               erase_block_bytes
);

  localparam int BIW = $clog2(NUM_BANKS);

  typedef enum logic [3:0] {
    ST_IDLE, ST_LEAD, ST_GAP, ST_SETUP, ST_STROBE, ST_HOLD, ST_IDLE_HOLD, ST_RB, ST_RESP
  } seq_state_e;

  seq_state_e        state;
  seq_state_e        next_state;
  seq_state_e        xfer_state;
  logic [TW-1:0]     next_load;
  logic [TW-1:0]     xfer_load;
  logic [31:0]       opt [NUM_BANKS];
  logic [31:0]       cur_opt;
  logic [31:0]       eff_opt;
  nand_op_e          cur_op;
  nand_op_e          eff_op;
  logic              cur_end;
  logic              hit_found;
  logic [BIW-1:0]    hit_bank;
  logic              cs_active;
  logic [BIW-1:0]    cs_bank;
  logic              wr_since;
  logic              ca_since;
  logic              need_lead;
  logic              need_gap;
  logic              accept;
  logic              seq_expired;
  logic              rb_expired;
  logic              rb_load;
  logic              apb_access;
  logic              opt_hit;
  logic [BIW-1:0]    opt_idx;
  logic [31:0]       status_word;
  logic              relaxed_timing;
  logic [SCY_W-1:0]  cycle_length;
  int                wait_q;
  int                lead_q;
  int                setup_q;
  int                hold_q;
  int                strobe_q;
  int                gap_q;
  int                rb_q;
  int                idle_q;

  // Register bus decode
  assign apb_access = psel & penable;
  assign opt_hit    = ((paddr & OPT_DEC_MASK) == OPT_BASE_ADDR)
                      && (int'(paddr[5:3]) < NUM_BANKS);
  assign opt_idx    = BIW'(paddr[5:3]);

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++)
    begin : g_opt
      bank_option_reg #(
        .RESET_VAL ((g == 0) ? BANK0_RESET : OPT_RESET)
      ) u_opt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (apb_access & pready & pwrite & opt_hit & (opt_idx == BIW'(g))),
        .wdata    (pwdata),
        .value    (opt[g])
      );
    end
  endgenerate

  always_comb
  begin
    status_word = '0;
    status_word[STAT_BUSY_BIT] = (state != ST_IDLE);
    status_word[STAT_CS_BIT] = cs_active;
    status_word[STAT_BANK_LSB +: BIW] = cs_bank;
    status_word[STAT_RB_BIT] = rb_expired;
    status_word[STAT_WR_BIT] = wr_since;
    status_word[STAT_CA_BIT] = ca_since;
  end

  // One wait cycle in the access phase, then the answer with read data
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= apb_access & ~pready;
      pslverr <= 1'b0;
      if (apb_access && !pready)
      begin
        if (opt_hit)
          prdata <= opt[opt_idx];
        else if (paddr == STATUS_ADDR)
          prdata <= status_word;
        else
        begin
          prdata  <= '0;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Bank hit: lowest numbered NAND bank whose unmasked bits match
  always_comb
  begin
    hit_found = 1'b0;
    hit_bank  = '0;
    for (int i = NUM_BANKS - 1; i >= 0; i--)
    begin
      if (bank_is_nand[i]
          && (((req_addr[31:AM_LSB] ^ bank_base_flat[i*AM_W +: AM_W])
               & opt[i][31:AM_LSB]) == '0))
      begin
        hit_found = 1'b1;
        hit_bank  = BIW'(i);
      end
    end
  end

  assign accept    = req_valid && (state == ST_IDLE);
  assign eff_opt   = (state == ST_IDLE) ? opt[hit_bank] : cur_opt;
  assign eff_op    = (state == ST_IDLE) ? req_op : cur_op;
  assign relaxed_timing      = eff_opt[RELAXED_TIMING_BIT];
  assign cycle_length       = eff_opt[SCY_LSB +: SCY_W];
  assign need_lead = !cs_active || (cs_bank != hit_bank);
  assign need_gap  = ((eff_op == OP_RDATA) && wr_since)
                     || ((eff_op == OP_WDATA) && ca_since);

  // Phase lengths in core cycles (quarter bus clocks)
  always_comb
  begin
    wait_q   = int'(cycle_length) * (relaxed_timing ? WAIT_RLX_MULT : 1) * QTR_PER_LBC;
    lead_q   = LEAD_LBC[{relaxed_timing, eff_opt[SELECT_LEAD_TIME_BIT]}] * QTR_PER_LBC;
    setup_q  = SETUP_QTR[{relaxed_timing, eff_opt[CST_BIT]}];
    hold_q   = HOLD_QTR[{relaxed_timing, eff_opt[CHT_BIT]}];
    strobe_q = ((eff_op == OP_RDATA) ? RDSETUP_QTR[{relaxed_timing, eff_opt[RST_BIT]}]
                : STROBE_LBC * QTR_PER_LBC) + wait_q;
    gap_q    = (relaxed_timing ? GAP_MULT_RLX : GAP_MULT_NORM) * (SCY_BASE + int'(cycle_length))
               * QTR_PER_LBC;
    rb_q     = (relaxed_timing ? RB_MULT_RLX : RB_MULT_NORM) * (SCY_BASE + int'(cycle_length))
               * QTR_PER_LBC;
    idle_q   = IDLE_LBC[{relaxed_timing, eff_opt[READ_HOLD_EXTEND_BIT]}] * QTR_PER_LBC;
  end

  // First phase of the transfer proper; a zero setup is skipped
  always_comb
  begin
    if (eff_op == OP_WAIT_RB)
    begin
      xfer_state = ST_RB;
      xfer_load  = '0;
    end
    else if ((eff_op == OP_RDATA) || (setup_q == 0))
    begin
      xfer_state = ST_STROBE;
      xfer_load  = TW'(strobe_q - 1);
    end
    else
    begin
      xfer_state = ST_SETUP;
      xfer_load  = TW'(setup_q - 1);
    end
  end

  always_comb
  begin
    next_state = state;
    next_load  = '0;
    case (state)
      ST_IDLE:
        if (req_valid)
        begin
          if (!hit_found)
            next_state = ST_RESP;
          else if (need_lead)
          begin
            next_state = ST_LEAD;
            next_load  = TW'(lead_q - 1);
          end
          else if (need_gap)
          begin
            next_state = ST_GAP;
            next_load  = TW'(gap_q - 1);
          end
          else
          begin
            next_state = xfer_state;
            next_load  = xfer_load;
          end
        end
      ST_LEAD:
        if (seq_expired)
        begin
          if (need_gap)
          begin
            next_state = ST_GAP;
            next_load  = TW'(gap_q - 1);
          end
          else
          begin
            next_state = xfer_state;
            next_load  = xfer_load;
          end
        end
      ST_GAP:
        if (seq_expired)
        begin
          next_state = xfer_state;
          next_load  = xfer_load;
        end
      ST_SETUP:
        if (seq_expired)
        begin
          next_state = ST_STROBE;
          next_load  = TW'(strobe_q - 1);
        end
      ST_STROBE:
        if (seq_expired)
        begin
          if (cur_op == OP_RDATA)
          begin
            next_state = ST_IDLE_HOLD;
            next_load  = TW'(idle_q - 1);
          end
          else
          begin
            next_state = ST_HOLD;
            next_load  = TW'(hold_q - 1);
          end
        end
      ST_HOLD:
        if (seq_expired)
          next_state = ST_RESP;
      ST_IDLE_HOLD:
        if (seq_expired)
          next_state = ST_RESP;
      ST_RB:
        if (rb_expired && flash_ready_busy_in)
          next_state = ST_RESP;
      ST_RESP:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  delay_timer #(
    .W (TW)
  ) u_seq_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (next_state != state),
    .load_val (next_load),
    .expired  (seq_expired)
  );

  // Ready/busy is blind from the end of a command strobe
  assign rb_load = (state == ST_STROBE) && seq_expired && (cur_op == OP_CMD);

  delay_timer #(
    .W (TW)
  ) u_rb_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (rb_load),
    .load_val (TW'(rb_q - 1)),
    .expired  (rb_expired)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Request capture and answer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cur_opt   <= '0;
      cur_op    <= OP_CMD;
      cur_end   <= 1'b0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_miss  <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      req_ready <= (next_state == ST_IDLE);
      rsp_valid <= (next_state == ST_RESP);
      if (accept)
      begin
        cur_opt  <= opt[hit_bank];
        cur_op   <= req_op;
        cur_end  <= req_end;
        rsp_miss <= !hit_found;
      end
      if ((state == ST_STROBE) && seq_expired && (cur_op == OP_RDATA))
        rsp_rdata <= flash_data_in;
    end
  end

  // Write history that decides the pre-data gap
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_since <= 1'b0;
      ca_since <= 1'b0;
    end
    else if (accept && hit_found && need_lead)
    begin
      wr_since <= 1'b0;
      ca_since <= 1'b0;
    end
    else if ((state == ST_STROBE) && seq_expired)
    begin
      wr_since <= (cur_op != OP_RDATA);
      ca_since <= (cur_op == OP_CMD) || (cur_op == OP_ADDR);
    end
  end

  // Bank select, and buffer control unless its disable bit is set in the option word, stay on until a request marked last ends
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bank_select_n  <= '1;
      cs_active      <= 1'b0;
      cs_bank        <= '0;
      buffer_ctl_out <= 1'b0;
    end
    else if (accept && hit_found)
    begin
      bank_select_n  <= ~(NUM_BANKS'(1) << hit_bank);
      cs_active      <= 1'b1;
      cs_bank        <= hit_bank;
      buffer_ctl_out <= !opt[hit_bank][BUFFER_CTL_DISABLE_BIT];
    end
    else if ((state == ST_RESP) && cur_end)
    begin
      bank_select_n  <= '1;
      cs_active      <= 1'b0;
      buffer_ctl_out <= 1'b0;
    end
  end

  // Flash strobes, latch enables and data drive follow the next phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      flash_write_strobe_n <= 1'b1;
      flash_read_strobe_n  <= 1'b1;
      flash_cle            <= 1'b0;
      flash_ale            <= 1'b0;
      flash_data_oe        <= 1'b0;
      flash_data_out       <= '0;
    end
    else
    begin
      flash_write_strobe_n <= !((next_state == ST_STROBE) && (eff_op != OP_RDATA));
      flash_read_strobe_n  <= !((next_state == ST_STROBE) && (eff_op == OP_RDATA));
      flash_cle     <= (eff_op == OP_CMD) && ((next_state == ST_SETUP)
                       || (next_state == ST_STROBE) || (next_state == ST_HOLD));
      flash_ale     <= (eff_op == OP_ADDR) && ((next_state == ST_SETUP)
                       || (next_state == ST_STROBE) || (next_state == ST_HOLD));
      flash_data_oe <= (eff_op != OP_RDATA) && ((next_state == ST_SETUP)
                       || (next_state == ST_STROBE) || (next_state == ST_HOLD));
      if (accept)
        flash_data_out <= req_wdata;
    end
  end

  // Geometry of the bank in use
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      page_main_bytes   <= SMALL_MAIN;
      page_spare_bytes  <= SMALL_SPARE;
      buffer_bytes      <= SMALL_BUF;
      erase_block_bytes <= SMALL_BLOCK;
    end
    else if (accept && hit_found)
    begin
      if (opt[hit_bank][PGS_BIT])
      begin
        page_main_bytes   <= LARGE_MAIN;
        page_spare_bytes  <= LARGE_SPARE;
        buffer_bytes      <= LARGE_BUF;
        erase_block_bytes <= LARGE_BLOCK;
      end
      else
      begin
        page_main_bytes   <= SMALL_MAIN;
        page_spare_bytes  <= SMALL_SPARE;
        buffer_bytes      <= SMALL_BUF;
        erase_block_bytes <= SMALL_BLOCK;
      end
    end
  end

endmodule

// File: tb/nand_flash_chk.sv
// Port-level checks for the NAND bank option timing block
`timescale 1ns/100ps
module nand_flash_chk
  import nand_bank_pkg::*;
#(
  parameter int NUM_BANKS = 8
)
(
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [31:0]          prdata,
  input wire logic                 req_valid,
  input wire logic                 req_ready,
  input wire logic                 rsp_valid,
  input wire logic                 rsp_miss,
  input wire logic [NUM_BANKS-1:0] bank_select_n,
  input wire logic                 flash_write_strobe_n,
  input wire logic                 flash_read_strobe_n,
  input wire logic                 flash_data_oe,
  input wire logic                 buffer_ctl_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic desel = &bank_select_n;
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response with data");
  a_lead_min: assert property ($fell(desel) |-> (flash_write_strobe_n && flash_read_strobe_n)[*4])
    else $error("select lead too short");
  a_we_width: assert property ($fell(flash_write_strobe_n) |-> (!flash_write_strobe_n)[*4])
    else $error("write strobe too short");
  a_we_hold: assert property ($rose(flash_write_strobe_n) |-> flash_data_oe[*2])
    else $error("write data hold too short");
  a_re_width: assert property ($fell(flash_read_strobe_n) |-> (!flash_read_strobe_n)[*2])
    else $error("read strobe too short");
  a_strobe_sel: assert property (!(flash_write_strobe_n && flash_read_strobe_n) |-> !desel)
    else $error("strobe without select");
  a_bus_turn: assert property (!flash_read_strobe_n |-> !flash_data_oe)
    else $error("bus driven during read");
  a_buf_ctl: assert property (buffer_ctl_out |-> !desel)
    else $error("buffer control without select");
  a_miss_fast: assert property (rsp_valid && rsp_miss |-> $past(req_valid && req_ready, 1))
    else $error("miss answer timing");
  cover property (rsp_valid && rsp_miss);
  cover property ($fell(flash_read_strobe_n));
  cover property (pslverr);
endmodule

bind nand_bank_option_timing nand_flash_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (
  .core_clk             (core_clk),
  .rst_n                (rst_n),
  .psel                 (psel),
  .penable              (penable),
  .pready               (pready),
  .pslverr              (pslverr),
  .prdata               (prdata),
  .req_valid            (req_valid),
  .req_ready            (req_ready),
  .rsp_valid            (rsp_valid),
  .rsp_miss             (rsp_miss),
  .bank_select_n        (bank_select_n),
  .flash_write_strobe_n (flash_write_strobe_n),
  .flash_read_strobe_n  (flash_read_strobe_n),
  .flash_data_oe        (flash_data_oe),
  .buffer_ctl_out       (buffer_ctl_out)
);

// File: tb/nand_flash_model.sv
// Behavioural NAND flash device on bank zero
`timescale 1ns/100ps
module nand_flash_model #(
  parameter int BUSY_CYC = 12
)
(
  input  wire logic       core_clk,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       we_n,
  input  wire logic       re_n,
  output logic      [7:0] dout,
  output logic            rb
);
  logic [7:0] rd_byte = 8'h5a;
  logic [7:0] last    = 8'h00;
  logic       we_q    = 1'b1;
  logic       re_q    = 1'b1;
  int         busy    = 0;
  // Undriven bus shows the inverse of the last byte
  assign dout = (!ce_n && !re_n) ? rd_byte : ~last;
  assign rb   = (busy == 0);
  always @(posedge core_clk)
  begin
    we_q <= we_n;
    re_q <= re_n;
    if (we_n && !we_q && cle)
      busy <= BUSY_CYC;
    else if (busy > 0)
      busy <= busy - 1;
    if (re_n && !re_q && !ce_n)
    begin
      last    <= rd_byte;
      rd_byte <= rd_byte + 8'h01;
    end
  end
endmodule

// File: tb/nand_bank_option_timing_tb_top.sv
// Random and corner tests for the NAND bank option timing block
`timescale 1ns/100ps
module nand_bank_option_timing_tb_top
  import nand_bank_pkg::*;
;
  logic         core_clk, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic         req_valid = 0, req_end = 0, er, t, a, b;
  logic [15:0]  paddr = 16'h0;
  logic [31:0]  pwdata = 32'h0, prdata, req_addr = 32'h0, rd, v;
  logic [7:0]   req_wdata = 8'h0, rsp_rdata, fdin, fdout, bsel_n, is_nand = 8'h01;
  logic [135:0] base = '0;
  logic         pready, pslverr, req_ready, rsp_valid, rsp_miss, cle, ale, we_n, re_n, oe;
  logic         bctl, rb;
  logic [11:0]  pg_main;
  logic [6:0]   pg_spare;
  logic [12:0]  buf_b;
  logic [17:0]  blk;
  logic [7:0]   exp_rd = 8'h5a;
  nand_op_e     req_op = OP_CMD;
  int           num_errors, total_checks, cl, c_lead, c_set, c_we, c_hold, c_re, c_idle;
  int           c_since, c_cle, c_ale;
  bit           s_we, s_re;

  nand_bank_option_timing DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bank_base_flat(base), .bank_is_nand(is_nand),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_end(req_end), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_miss(rsp_miss),
    .rsp_rdata(rsp_rdata), .bank_select_n(bsel_n), .flash_cle(cle), .flash_ale(ale),
    .flash_write_strobe_n(we_n), .flash_read_strobe_n(re_n), .flash_data_out(fdout),
    .flash_data_oe(oe), .flash_data_in(fdin), .flash_ready_busy_in(rb),
    .buffer_ctl_out(bctl), .page_main_bytes(pg_main), .page_spare_bytes(pg_spare),
    .buffer_bytes(buf_b), .erase_block_bytes(blk));
  nand_flash_model u_flash (.core_clk(core_clk), .ce_n(bsel_n[0]), .cle(cle), .we_n(we_n),
    .re_n(re_n), .dout(fdin), .rb(rb));

  initial
  begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end

  // Phase lengths of the current request, in core cycles
  always @(posedge core_clk)
  begin
    c_since = we_n ? c_since + 1 : 0;
    if (req_valid && req_ready)
      {c_lead, c_set, c_we, c_hold, c_re, c_idle, c_cle, c_ale, s_we, s_re} = 0;
    else if (!rsp_valid)
    begin
      c_lead += (!(&bsel_n) && !oe && we_n && re_n && !s_we && !s_re);
      c_set  += (oe && we_n && !s_we);
      c_we   += !we_n;
      c_hold += (oe && we_n && s_we);
      c_re   += !re_n;
      c_idle += (re_n && s_re);
      c_cle  += cle;
      c_ale  += ale;
      s_we |= !we_n;
      s_re |= !re_n;
    end
  end

  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok)
    begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  function automatic int ws(input bit tr, input int len);
    return len * (tr ? 2 : 1) * 4;
  endfunction

  task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 0;
    penable <= 0;
    chk(n < 50, "apb timeout");
    @(posedge core_clk);
  endtask

  task automatic op(input nand_op_e o, input logic [31:0] ad, input logic e);
    int n;
    n = 0;
    req_valid <= 1;
    req_op    <= o;
    req_addr  <= ad;
    req_wdata <= 8'($urandom);
    req_end   <= e;
    do
      @(posedge core_clk);
    while (req_ready !== 1'b1);
    req_valid <= 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 3000);
    chk(n < 3000, "request timeout");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    conclude();
  end

  initial
  begin
    void'($urandom(41346));
    repeat (5) @(posedge core_clk);
    rst_n <= 1;
    for (int i = 0; i < 8; i++)
    begin
      apb(0, OPT_BASE_ADDR + 16'(8 * i), 0);
      chk(rd === 32'h0 && er === 1'b0, "reset value");
      v = $urandom;
      apb(1, OPT_BASE_ADDR + 16'(8 * i), v);
      apb(0, OPT_BASE_ADDR + 16'(8 * i), 0);
      chk(rd === (v & OPT_WRITABLE), "readback");
    end
    apb(0, 16'h5000, 0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
    $display("register test done");
    for (int k = 0; k < 8; k++)
    begin
      t = k[0];
      a = k[1];
      b = k[2];
      cl = $urandom_range(7);
      v = {19'h0, 1'($urandom), 1'b0, 1'($urandom), a, a, b, 3'(cl), b, t, a ^ b, 1'b0};
      apb(1, OPT_BASE_ADDR, v);
      op(OP_CMD, $urandom, 0);
      chk(c_lead === LEAD_LBC[{t, a}] * 4, "select lead");
      chk(c_set === SETUP_QTR[{t, a}], "write setup");
      chk(c_we === 4 + ws(t, cl), "write strobe");
      chk(c_cle === c_set + c_we + c_hold && c_ale === 0, "command latch");
      chk(c_hold === HOLD_QTR[{t, b}], "write hold");
      chk(bctl === !v[12], "buffer control");
      chk({pg_main, pg_spare, buf_b, blk} === (v[10] ? {LARGE_MAIN, LARGE_SPARE, LARGE_BUF,
        LARGE_BLOCK} : {SMALL_MAIN, SMALL_SPARE, SMALL_BUF, SMALL_BLOCK}), "geometry");
      apb(0, STATUS_ADDR, 0);
      chk(rd === 32'h0000_0602 && er === 1'b0, "status");
      op(OP_WAIT_RB, 0, 0);
      chk(c_since >= (t ? RB_MULT_RLX : RB_MULT_NORM) * (2 + cl) * 4, "ready blind");
      op(OP_RDATA, 0, 1);
      chk(c_lead === (t ? GAP_MULT_RLX : GAP_MULT_NORM) * (2 + cl) * 4, "data gap");
      chk(c_re === RDSETUP_QTR[{t, b}] + ws(t, cl), "read strobe");
      chk(c_idle === IDLE_LBC[{t, a ^ b}] * 4, "read idle");
      chk(rsp_rdata === exp_rd, "read data");
      exp_rd++;
      $display("timing test %0d done", k);
    end
    op(OP_ADDR, 0, 0);
    chk(c_ale === c_set + c_we + c_hold && c_cle === 0 && fdout === req_wdata, "addr");
    op(OP_WDATA, 0, 1);
    chk(c_lead === GAP_MULT_RLX * (2 + cl) * 4 && c_ale === 0, "write data gap");
    for (int j = 15; j < 32; j++)
    begin
      apb(1, OPT_BASE_ADDR, 32'h1 << j);
      op(OP_CMD, 32'h1 << j, 1);
      chk(rsp_miss === 1'b1 && c_we === 0, "masked bit");
      op(OP_CMD, ~(32'h1 << j), 1);
      chk(rsp_miss === 1'b0, "ignored bit");
    end
    is_nand <= 8'h00;
    op(OP_CMD, 0, 1);
    chk(rsp_miss === 1'b1 && c_we === 0, "other machine");
    $display("bank match test done");
    conclude();
  end
endmodule
